// ---- pkg/dmarc_pkg.sv ----
/*
 * dmarc_pkg: shared constants, register indices, control field positions,
 * engine states and helper functions of the eight-channel transfer controller.
 * Assumes a 16-bit register view carried in the low half of a 32-bit
 * classic Wishbone data bus, one aligned word per register.
 */
`default_nettype none
package dmarc_pkg;
    // channel count and widths
    localparam int NCH = 8;
    localparam int CH_W = 3;
    localparam int DW = 16;
    localparam int CNT_W = 10;
    localparam int SRC_W = 7;
    localparam int NSRC = 128;
    localparam int ADR_W = 9;
    localparam int MEM_AW = 5;
    // byte address fields: shared flag, channel, register
    localparam int A_SH = 8;
    localparam int A_CH = 5;
    localparam int A_RG = 2;
    // per-channel register indices
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_REQ = 3'h1;
    localparam logic [2:0] REG_STA = 3'h2;
    localparam logic [2:0] REG_STB = 3'h3;
    localparam logic [2:0] REG_PAD = 3'h4;
    localparam logic [2:0] REG_CNT = 3'h5;
    // shared register indices
    localparam logic [2:0] SH_COLL = 3'h0;
    localparam logic [2:0] SH_PING = 3'h1;
    localparam logic [2:0] SH_IRQ = 3'h2;
    localparam logic [2:0] SH_MASK = 3'h3;
    // control word fields
    localparam int C_ON = 15;
    localparam int C_BYTE = 14;
    localparam int C_DIR = 13;
    localparam int C_HALF = 12;
    localparam int C_NULL = 11;
    localparam int C_AM = 4;
    localparam int C_ONESHOT = 1;
    localparam int C_PP = 0;
    localparam logic [15:0] CTRL_WMASK = 16'hf833;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // addressing modes
    localparam logic [1:0] AM_INC = 2'h0;
    localparam logic [1:0] AM_NOINC = 2'h1;
    localparam logic [1:0] AM_PIND = 2'h2;
    localparam logic [1:0] AM_RSVD = 2'h3;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] BYTE_MASK = 16'h00ff;
    // transfer engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_PAD, ST_CNT, ST_START, ST_LOAD, ST_READ, ST_WRITE, ST_UPD
    } dmarc_state_type;
    // byte-lane merge of a 16-bit write
    function automatic logic [15:0] dmarc_merge(input logic [15:0] old,
                                                input logic [15:0] wd,
                                                input logic [1:0] be);
        dmarc_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : dmarc_merge
    // memory word of a channel's address or count register
    function automatic logic [MEM_AW-1:0] dmarc_idx(input logic [CH_W-1:0] ch,
                                                    input logic [2:0] rg);
        logic [2:0] off;
        off = rg - REG_STA;
        dmarc_idx = {ch, off[1:0]};
    endfunction : dmarc_idx
endpackage : dmarc_pkg
`default_nettype wire

// ---- rtl/dmarc_mem.sv ----
/*
 * dmarc_mem: small word store with one byte-enabled write port and two
 * registered read ports. Assumes one clock; contents are not reset, so
 * software writes a word before any reader relies on it.
 */
`default_nettype none
module dmarc_mem #(
    parameter int W = 16,
    parameter int AW = 5
) (
    input wire logic clk_i,
    input wire logic a_we_i,
    input wire logic [W/8-1:0] a_be_i,
    input wire logic [AW-1:0] a_addr_i,
    input wire logic [W-1:0] a_wdata_i,
    output logic [W-1:0] a_rdata_o,
    input wire logic [AW-1:0] b_addr_i,
    output logic [W-1:0] b_rdata_o
);
    // storage array
    logic [W-1:0] mem [2**AW];

    // byte-lane write and registered reads
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < W / 8; i++) begin
            if (a_we_i && a_be_i[i]) begin
                mem[a_addr_i][i*8 +: 8] <= a_wdata_i[i*8 +: 8];
            end
        end
        a_rdata_o <= mem[a_addr_i];
        b_rdata_o <= mem[b_addr_i];
    end
endmodule : dmarc_mem
`default_nettype wire

// ---- rtl/dmarc_top.sv ----
/*
 * dmarc_top: eight-channel transfer controller with register control over
 * classic Wishbone, fixed-priority arbitration and a simple move engine
 * between a dual-port RAM and peripheral registers.
 * Assumes all inputs synchronous to clk_i and one-cycle read latency on
 * both the RAM and the peripheral side.
 */
// Overview of operation
// - eight identical channels, each own registers
// - sixteen-bit control, select, start, peripheral registers
// - transfer count register is ten bits
// - plain registers read back last written value
// - start address reads return live pointer
// - shared register holds both collision flags
// - shared register shows activity and buffer
// - completion flags kept outside channel registers
// - top bit enables channel; resets zero
// - bit fourteen selects byte or word
// - bit thirteen selects transfer direction
// - bit twelve moves interrupt to half
// - null mode writes zero to peripheral on peripheral to ram moves
// - unimplemented control bits read zero
// - reserved mode acts as peripheral indirect
// - interrupt at block end or half
// - fixed priority, lowest channel wins
`default_nettype none
module dmarc_top
    import dmarc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic [NSRC-1:0] src_req_i,
    input wire logic [DW-1:0] pind_addr_i,
    output logic ram_re_o,
    output logic ram_we_o,
    output logic [DW-1:0] ram_addr_o,
    output logic [DW-1:0] ram_wdata_o,
    input wire logic [DW-1:0] ram_rdata_i,
    input wire logic ram_coll_i,
    output logic per_re_o,
    output logic per_we_o,
    output logic [DW-1:0] per_addr_o,
    output logic [DW-1:0] per_wdata_o,
    input wire logic [DW-1:0] per_rdata_i,
    input wire logic per_coll_i,
    output logic xfer_byte_o
);
    // per-channel register state
    logic [DW-1:0] ctrl_r [NCH];
    logic [DW-1:0] req_r [NCH];
    logic [DW-1:0] ptr_r [NCH];
    logic [CNT_W-1:0] done_r [NCH];
    logic [NCH-1:0] pend_r;
    logic [NCH-1:0] reload_r;
    logic [NCH-1:0] ppsel_r;
    // shared status, interrupt and bus state
    logic [DW-1:0] coll_r;
    logic [NCH-1:0] irq_stat_r;
    logic [NCH-1:0] irq_mask_r;
    logic irq_r;
    logic ack_r;
    logic ph_r;
    logic [31:0] dat_r;
    // engine state
    dmarc_state_type state_r;
    logic [CH_W-1:0] gnt_r;
    logic [DW-1:0] pad_r;
    logic [CNT_W-1:0] cnt_r;
    // registered link outputs
    logic ram_re_r, ram_we_r, per_re_r, per_we_r, byte_r;
    logic [DW-1:0] ram_addr_r, ram_wdata_r, per_addr_r, per_wdata_r;

    // bus decode
    logic bus_req, bus_sh, wr_go, rd_go;
    logic [CH_W-1:0] bus_ch;
    logic [2:0] bus_reg;
    logic [DW-1:0] bus_wd;
    logic [1:0] bus_be;
    logic mem_we;
    logic [DW-1:0] mem_a_rd, mem_b_rd;
    logic [MEM_AW-1:0] mem_b_addr;
    // engine helpers
    logic [DW-1:0] gctl, cur_ptr, src_data, ptr_cur, req_cur;
    logic [1:0] am;
    logic indirect, last, half_hit, upd;
    logic [CNT_W:0] hsum;
    logic [NCH-1:0] g_oh, ev, on_vec;
    logic [CH_W-1:0] pick;

    // lowest pending channel number
    function automatic logic [CH_W-1:0] pick_low(input logic [NCH-1:0] v);
        pick_low = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                pick_low = CH_W'(i);
            end
        end
    endfunction : pick_low

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r && !ph_r;
    assign bus_sh = wb_adr_i[A_SH];
    assign bus_ch = wb_adr_i[A_CH +: CH_W];
    assign bus_reg = wb_adr_i[A_RG +: 3];
    assign bus_wd = wb_dat_i[DW-1:0];
    assign bus_be = wb_sel_i[1:0];
    assign wr_go = ph_r && wb_we_i;
    assign rd_go = ph_r && !wb_we_i;
    assign mem_we = wr_go && !bus_sh && bus_reg >= REG_STA && bus_reg <= REG_CNT;
    assign ptr_cur = ptr_r[bus_ch];
    assign req_cur = req_r[bus_ch];

    // start, peripheral address and count words
    dmarc_mem #(.W(DW), .AW(MEM_AW)) u_mem (
        .clk_i(clk_i),
        .a_we_i(mem_we),
        .a_be_i(bus_be),
        .a_addr_i(dmarc_idx(bus_ch, bus_reg)),
        .a_wdata_i(bus_wd),
        .a_rdata_o(mem_a_rd),
        .b_addr_i(mem_b_addr),
        .b_rdata_o(mem_b_rd)
    );

    // engine decode of the granted channel
    always_comb begin
        gctl = ctrl_r[gnt_r];
        am = gctl[C_AM +: 2];
        indirect = (am == AM_PIND) || (am == AM_RSVD);
        cur_ptr = reload_r[gnt_r] ? mem_b_rd : ptr_r[gnt_r];
        src_data = gctl[C_DIR] ? ram_rdata_i : per_rdata_i;
        if (gctl[C_BYTE]) begin
            src_data = src_data & BYTE_MASK;
        end
        hsum = {1'b0, cnt_r} + 1'b1;
        last = done_r[gnt_r] == cnt_r;
        half_hit = done_r[gnt_r] == CNT_W'((hsum >> 1) - 1'b1);
        upd = state_r == ST_UPD;
        g_oh = '0;
        g_oh[gnt_r] = 1'b1;
        ev = (upd && (gctl[C_HALF] ? half_hit : last)) ? g_oh : '0;
        for (int c = 0; c < NCH; c++) begin
            on_vec[c] = ctrl_r[c][C_ON];
        end
        // a request left over from a channel just switched off is never granted
        pick = pick_low(pend_r & on_vec);
    end

    // engine read port address per state
    always_comb begin
        unique case (state_r)
            ST_PAD: mem_b_addr = dmarc_idx(gnt_r, REG_PAD);
            ST_CNT: mem_b_addr = dmarc_idx(gnt_r, REG_CNT);
            ST_START: mem_b_addr = dmarc_idx(gnt_r, ppsel_r[gnt_r] ? REG_STB : REG_STA);
            default: mem_b_addr = dmarc_idx(gnt_r, REG_STA);
        endcase
    end

    // wishbone handshake: take, then answer one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            ph_r <= bus_req;
            ack_r <= ph_r;
        end
    end

    // read data mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_go) begin
            dat_r <= 32'h0000_0000;
            if (bus_sh) begin
                // shared registers
                unique case (bus_reg)
                    SH_COLL: dat_r[DW-1:0] <= coll_r;
                    SH_PING: dat_r[DW-1:0] <= {ppsel_r,
                        (state_r != ST_IDLE) ? g_oh : {NCH{1'b0}}};
                    SH_IRQ: dat_r[NCH-1:0] <= irq_stat_r;
                    SH_MASK: dat_r[NCH-1:0] <= irq_mask_r;
                    default: dat_r <= 32'h0000_0000;
                endcase
            end else begin
                // channel registers
                unique case (bus_reg)
                    REG_CTRL: dat_r[DW-1:0] <= ctrl_r[bus_ch];
                    REG_REQ: dat_r[DW-1:0] <= req_cur;
                    REG_STA, REG_STB: dat_r[DW-1:0] <= ptr_cur;
                    REG_PAD: dat_r[DW-1:0] <= mem_a_rd;
                    REG_CNT: dat_r[CNT_W-1:0] <= mem_a_rd[CNT_W-1:0];
                    default: dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control and request select registers
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NCH; c++) begin
            if (rst_i) begin
                ctrl_r[c] <= CTRL_RST;
                req_r[c] <= 16'h0000;
            end else if (wr_go && !bus_sh && bus_ch == CH_W'(c)) begin
                if (bus_reg == REG_CTRL) begin
                    ctrl_r[c] <= dmarc_merge(ctrl_r[c], bus_wd, bus_be) & CTRL_WMASK;
                end
                if (bus_reg == REG_REQ) begin
                    req_r[c] <= dmarc_merge(req_r[c], bus_wd, bus_be);
                end
            end else if (upd && last && gnt_r == CH_W'(c) && ctrl_r[c][C_ONESHOT]) begin
                // one-shot channel turns itself off
                ctrl_r[c][C_ON] <= 1'b0;
            end
        end
    end

    // per-channel request, reload and buffer state
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NCH; c++) begin
            if (rst_i || !ctrl_r[c][C_ON]) begin
                pend_r[c] <= 1'b0;
                reload_r[c] <= 1'b1;
                ppsel_r[c] <= 1'b0;
            end else begin
                // request set wins over grant clear
                if (src_req_i[req_r[c][SRC_W-1:0]]) begin
                    pend_r[c] <= 1'b1;
                end else if (state_r == ST_IDLE && |(pend_r & on_vec) && pick == CH_W'(c)) begin
                    pend_r[c] <= 1'b0;
                end
                if (upd && last && gnt_r == CH_W'(c)) begin
                    reload_r[c] <= 1'b1;
                    ppsel_r[c] <= ppsel_r[c] ^ ctrl_r[c][C_PP];
                end else if (state_r == ST_LOAD && gnt_r == CH_W'(c)) begin
                    reload_r[c] <= 1'b0;
                end
            end
        end
    end

    // pointer and progress counters
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NCH; c++) begin
            if (rst_i || !ctrl_r[c][C_ON]) begin
                done_r[c] <= '0;
            end else if (upd && gnt_r == CH_W'(c)) begin
                done_r[c] <= last ? '0 : done_r[c] + 1'b1;
            end
            if (rst_i) begin
                ptr_r[c] <= 16'h0000;
            end else if (state_r == ST_LOAD && gnt_r == CH_W'(c)) begin
                ptr_r[c] <= cur_ptr;
            end else if (upd && gnt_r == CH_W'(c) && am == AM_INC) begin
                ptr_r[c] <= ptr_r[c] + (gctl[C_BYTE] ? STEP_BYTE : STEP_WORD);
            end
        end
    end

    // transfer engine sequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            gnt_r <= '0;
            pad_r <= 16'h0000;
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (|(pend_r & on_vec)) begin
                        gnt_r <= pick;
                        state_r <= ST_PAD;
                    end
                end
                ST_PAD: state_r <= ST_CNT;
                ST_CNT: begin
                    pad_r <= mem_b_rd;
                    state_r <= ST_START;
                end
                ST_START: begin
                    cnt_r <= mem_b_rd[CNT_W-1:0];
                    state_r <= ST_LOAD;
                end
                ST_LOAD: state_r <= ST_READ;
                ST_READ: state_r <= ST_WRITE;
                ST_WRITE: state_r <= ST_UPD;
                ST_UPD: state_r <= ST_IDLE;
            endcase
        end
    end

    // link strobes, addresses and data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_re_r <= 1'b0;
            ram_we_r <= 1'b0;
            per_re_r <= 1'b0;
            per_we_r <= 1'b0;
            byte_r <= 1'b0;
            ram_addr_r <= 16'h0000;
            per_addr_r <= 16'h0000;
            ram_wdata_r <= 16'h0000;
            per_wdata_r <= 16'h0000;
        end else begin
            ram_re_r <= 1'b0;
            per_re_r <= 1'b0;
            ram_we_r <= 1'b0;
            per_we_r <= 1'b0;
            if (state_r == ST_LOAD) begin
                ram_addr_r <= indirect ? pind_addr_i : cur_ptr;
                per_addr_r <= pad_r;
                byte_r <= gctl[C_BYTE];
                ram_re_r <= gctl[C_DIR];
                per_re_r <= !gctl[C_DIR];
            end
            if (state_r == ST_WRITE) begin
                if (gctl[C_DIR]) begin
                    per_we_r <= 1'b1;
                    per_wdata_r <= src_data;
                end else begin
                    ram_we_r <= 1'b1;
                    ram_wdata_r <= src_data;
                    per_we_r <= gctl[C_NULL];
                    per_wdata_r <= 16'h0000;
                end
            end
        end
    end

    // sticky collision flags, read clears, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coll_r <= 16'h0000;
        end else begin
            coll_r <= (rd_go && bus_sh && bus_reg == SH_COLL) ? 16'h0000 : coll_r;
            if (upd && ram_we_r && ram_coll_i) begin
                coll_r[gnt_r] <= 1'b1;
            end
            if (upd && per_we_r && per_coll_i) begin
                coll_r[NCH + 32'(gnt_r)] <= 1'b1;
            end
        end
    end

    // completion flags in separate interrupt registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            if (rd_go && bus_sh && bus_reg == SH_IRQ) begin
                irq_stat_r <= ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
            if (wr_go && bus_sh && bus_reg == SH_MASK && bus_be[0]) begin
                irq_mask_r <= bus_wd[NCH-1:0];
            end
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign irq_o = irq_r;
    assign ram_re_o = ram_re_r;
    assign ram_we_o = ram_we_r;
    assign ram_addr_o = ram_addr_r;
    assign ram_wdata_o = ram_wdata_r;
    assign per_re_o = per_re_r;
    assign per_we_o = per_we_r;
    assign per_addr_o = per_addr_r;
    assign per_wdata_o = per_wdata_r;
    assign xfer_byte_o = byte_r;

    // checks of register and transfer behaviour
    // read of control
    ctrl_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && !bus_sh && bus_reg == REG_CTRL |=> (dat_r[DW-1:0] & ~CTRL_WMASK) == 16'h0000)
        else $error("control reserved bits not zero");
    req_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && !bus_sh && bus_reg == REG_REQ |=> wb_dat_o[DW-1:0] == $past(req_cur))
        else $error("select read mismatch");
    ptr_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && !bus_sh && bus_reg == REG_STA |=> wb_dat_o[DW-1:0] == $past(ptr_cur))
        else $error("start read not live pointer");
    off_no_pend_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pend_r & ~$past(on_vec)) == '0)
        else $error("disabled channel pending");
    fixed_prio_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_IDLE && pend_r[0] && on_vec[0] |=> gnt_r == '0)
        else $error("priority order broken");
    dir_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ram_re_o |=> ##1 per_we_o && !ram_we_o)
        else $error("ram to peripheral sequence wrong");
    null_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ram_we_o && gctl[C_NULL] |-> per_we_o && per_wdata_o == 16'h0000)
        else $error("null write missing");
    byte_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ram_we_o || per_we_o) && xfer_byte_o |->
        ((ram_we_o ? ram_wdata_o : per_wdata_o) & ~BYTE_MASK) == 16'h0000)
        else $error("byte move upper lane set");
    reset_off_a: assert property (@(posedge clk_i)
        $past(rst_i) && !rst_i |-> on_vec == '0)
        else $error("channel on after reset");
    blk_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        upd && last && !gctl[C_HALF] |=> irq_stat_r[$past(gnt_r)])
        else $error("block end flag missing");

    bus_read_c: cover property (@(posedge clk_i) rd_go ##1 wb_ack_o);
    block_end_c: cover property (@(posedge clk_i) upd && last);
    null_mode_c: cover property (@(posedge clk_i) ram_we_o && per_we_o);
    half_irq_c: cover property (@(posedge clk_i) upd && gctl[C_HALF] && half_hit);
endmodule : dmarc_top
`default_nettype wire

// ---- testbench/dmarc_far.sv ----
/*
 * dmarc_far: behavioural ram and peripheral read side of the controller.
 * Assumes read data is expected one cycle after the read strobe.
 */
`default_nettype none
module dmarc_far (
    input wire logic clk_i,
    input wire logic ram_re_i,
    input wire logic per_re_i,
    input wire logic [15:0] ram_addr_i,
    input wire logic [15:0] per_addr_i,
    output logic [15:0] ram_rdata_o,
    output logic [15:0] per_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // data follows address one cycle after strobe; inverts when idle
    always_ff @(posedge clk_i) begin
        ram_rdata_o <= ram_re_i ? ram_addr_i ^ 16'h5a5a : ~ram_rdata_o;
        per_rdata_o <= per_re_i ? per_addr_i ^ 16'ha5a5 : ~per_rdata_o;
    end
endmodule : dmarc_far
`default_nettype wire

// ---- testbench/tb_top.sv ----
/*
 * tb_top: register, move and interrupt tests of dmarc_top.
 * Assumes the far side model dmarc_far and a 100 MHz clock.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dmarc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [8:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, dat_o;
    logic [127:0] src = 0;
    logic ack, irq_o, ram_re_o, ram_we_o, per_re_o, per_we_o, xb;
    logic [15:0] ram_addr_o, ram_wdata_o, rrd, per_addr_o, per_wdata_o, prd, q;
    logic [15:0] pind = 16'h0000;
    logic [1:0] coll = 2'h0;
    int n_errors = 0, checks_done = 0;
    dmarc_top dmarc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .irq_o(irq_o), .src_req_i(src), .pind_addr_i(pind),
        .ram_re_o(ram_re_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
        .ram_wdata_o(ram_wdata_o), .ram_rdata_i(rrd), .ram_coll_i(coll[0]), .per_re_o(per_re_o),
        .per_we_o(per_we_o), .per_addr_o(per_addr_o), .per_wdata_o(per_wdata_o),
        .per_rdata_i(prd), .per_coll_i(coll[1]), .xfer_byte_o(xb));
    dmarc_far dmarc_far_inst (.clk_i(clk_i), .ram_re_i(ram_re_o), .per_re_i(per_re_o),
        .ram_addr_i(ram_addr_o), .per_addr_i(per_addr_o), .ram_rdata_o(rrd),
        .per_rdata_o(prd));
    // free-running clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [8:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h3, 16'h0000, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 40);
        q = dat_o[15:0];
        if (n >= 40) chk("ack", 16'h1, 16'h0);
        {cyc, stb} <= 2'b00;
    endtask : wb
    // wait for a strobe from the engine, bounded
    task automatic wait_st(input bit p);
        int n;
        n = 0;
        do @(negedge clk_i); while (!(p ? per_we_o : ram_we_o) && ++n < 60);
    endtask : wait_st
    // reset value of channel 0 control and plain storage on every channel
    task automatic t_regs();
        wb(0, 9'h000, 0);
        chk("ctrl rst", 16'h0000, q);
        for (int c = 0; c < 8; c++) begin
            wb(1, 9'(c * 32), 16'h7fff);
            wb(0, 9'(c * 32), 0);
            chk("ctrl", 16'h7833, q);
            wb(1, 9'(c * 32 + 4), 16'h1200 + 16'(c));
            wb(0, 9'(c * 32 + 4), 0);
            chk("reqsel", 16'h1200 + 16'(c), q);
            wb(1, 9'(c * 32 + 20), 16'hfc00 + 16'(c));
            wb(0, 9'(c * 32 + 20), 0);
            chk("count", 16'(c), q);
            wb(1, 9'(c * 32), 0);
        end
        $display("t_regs done");
    endtask : t_regs
    // two word moves peripheral to ram with completion interrupt
    task automatic t_move();
        wb(1, 9'h048, 16'h0040);
        wb(1, 9'h050, 16'h0300);
        wb(1, 9'h054, 16'h0001);
        wb(1, 9'h044, 16'h0005);
        wb(1, 9'h10c, 16'h0004);
        wb(1, 9'h040, 16'h8802); // direction kept clear
        src[5] <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wait_st(0);
            chk("ram addr", 16'h0040 + 16'(2 * i), ram_addr_o);
            chk("ram data", 16'ha6a5, ram_wdata_o);
            chk("null we", 16'h1, {15'h0, per_we_o});
            chk("null data", 16'h0000, per_wdata_o);
        end
        @(posedge clk_i);
        src[5] <= 1'b0;
        repeat (4) @(negedge clk_i);
        chk("irq", 16'h1, {15'h0, irq_o});
        wb(0, 9'h108, 0);
        chk("irq stat", 16'h0004, q);
        wb(0, 9'h108, 0);
        chk("irq clr", 16'h0000, q);
        wb(0, 9'h040, 0);
        chk("oneshot", 16'h0802, q);
        wb(0, 9'h048, 0);
        chk("live ptr", 16'h0044, q);
        $display("t_move done");
    endtask : t_move
    // disabled channel stays quiet, then byte move ram to peripheral
    task automatic t_off_byte();
        int k;
        k = 0;
        src[5] <= 1'b1;
        repeat (30) @(negedge clk_i) k += ram_we_o;
        chk("off", 16'h0, 16'(k));
        @(posedge clk_i);
        src[5] <= 1'b0;
        wb(1, 9'h008, 16'h0081);
        wb(1, 9'h010, 16'h0200);
        wb(1, 9'h014, 16'h0000);
        wb(1, 9'h004, 16'h0006);
        wb(1, 9'h000, 16'he032); // reserved mode code
        pind <= 16'h0123;
        coll <= 2'b10;
        src[6] <= 1'b1;
        wait_st(1);
        chk("indirect", 16'h0123, ram_addr_o);
        chk("per addr", 16'h0200, per_addr_o);
        chk("per data", 16'h0079, per_wdata_o);
        chk("byte", 16'h1, {15'h0, xb});
        @(posedge clk_i);
        src[6] <= 1'b0;
        wb(0, 9'h100, 0);
        chk("coll", 16'h0100, q);
        wb(0, 9'h100, 0);
        chk("coll clr", 16'h0000, q);
        $display("t_off_byte done");
    endtask : t_off_byte
    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_move();
        t_off_byte();
        report_and_stop();
    end
    // watchdog
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
